/* rtl/swc_pkg.sv */
// Constants, types and layouts shared by the sleep/wake configuration block
// Operation
// - Divert bit clear: sleep-enable write starts sleep
// - Divert bit set: no sleep, raise SMI
// - Every sleep-enable write sets SMI flag
// - Source bit clear: wake status on power-on fall
// - Source bit set: also any enabled wake
package swc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] SWC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SWC_OFF_WAKE_EN = 8'h04;
  localparam logic [7:0] SWC_OFF_STATUS = 8'h08;
  localparam logic [7:0] SWC_OFF_CLEAR = 8'h0C;
  localparam logic [7:0] SWC_OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] SWC_OFF_CONFIG = 8'hF0;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and positions
  localparam int SWC_CFG_W = 2;
  localparam int SWC_TYPE_W = 3;
  localparam int SWC_WAKE_W = 8;
  localparam int SWC_ST_W = 3;
  localparam int SWC_CFG_DIVERT = 0;
  localparam int SWC_CFG_WSRC = 1;
  localparam int SWC_CTRL_SLP_EN = 0;
  localparam int SWC_CTRL_TYPE_LSB = 1;
  localparam int SWC_ST_WAKE = 0;
  localparam int SWC_ST_SMI = 1;
  localparam int SWC_ST_SLEEP = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [SWC_CFG_W-1:0] SWC_CFG_RST = 2'h0;
  localparam logic [SWC_TYPE_W-1:0] SWC_TYPE_RST = 3'h0;
  localparam logic [SWC_WAKE_W-1:0] SWC_WAKE_EN_RST = 8'h00;
  localparam logic [SWC_ST_W-1:0] SWC_ST_RST = 3'h0;
  localparam logic [SWC_ST_W-1:0] SWC_IRQ_EN_RST = 3'h0;
  localparam logic [31:0] SWC_DATA_RST = 32'h0000_0000;
  localparam logic [7:0] SWC_ADDR_RST = 8'h00;

  // Synchroniser depth for pin inputs, in flops
  localparam int SWC_SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus data-phase tracker, one-hot
  typedef enum logic [3:0] {
    SWC_PH_IDLE = 4'b0001,
    SWC_PH_WRITE = 4'b0010,
    SWC_PH_RWAIT = 4'b0100,
    SWC_PH_RDONE = 4'b1000
  } swc_phase_t;

  // Sleep request toward the sequencer
  typedef struct packed {
    logic start;
    logic [SWC_TYPE_W-1:0] kind;
  } swc_sleep_req_t;

  // Whole state of the top module
  typedef struct packed {
    swc_phase_t phase;
    logic [7:0] addr;
    logic hit;
    logic [SWC_CFG_W-1:0] cfg;
    logic [SWC_TYPE_W-1:0] slp_type;
    logic [SWC_WAKE_W-1:0] wake_en;
    logic [SWC_ST_W-1:0] status;
    logic [SWC_ST_W-1:0] irq_en;
    logic [31:0] rdata;
    swc_sleep_req_t req;
  } swc_state_t;

endpackage : swc_pkg

/* rtl/swc_sync_edge.sv */
// Two-flop pin synchroniser with registered edge pulses
`timescale 1ns/1ps
`default_nettype none
module swc_sync_edge #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } swc_sync_state_t;

  swc_sync_state_t state_r;
  swc_sync_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Meta stage feeds only the sync stage; edges look at sync and prev
  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = i_async;
    state_nxt.sync = state_r.meta;
    state_nxt.prev = state_r.sync;
    state_nxt.rise = state_r.sync & ~state_r.prev;
    state_nxt.fall = ~state_r.sync & state_r.prev;
  end

  // Reset meta, sync and prev to ones and the edge flags to zero so an idle-high pin gives no false fall
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= '{default: '1};
      state_r.rise <= '0;
      state_r.fall <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_level = state_r.sync;
  assign o_rise = state_r.rise;
  assign o_fall = state_r.fall;

endmodule : swc_sync_edge
`default_nettype wire

/* rtl/swc_top.sv */
// Sleep/wake configuration block with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module swc_top (
  input wire logic i_clock,
  input wire logic i_reset,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Pins
  input wire logic i_power_on_request_n,
  input wire logic [swc_pkg::SWC_WAKE_W-1:0] i_wake_event,
  // Toward sequencer and SMI logic
  output swc_pkg::swc_sleep_req_t o_sleep_req,
  output logic o_wake_sts,
  output logic o_smi,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match; used by both read and write decode
  function automatic logic reg_hit(
    input logic hit,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    reg_hit = hit && (addr == off);
  endfunction : reg_hit

  // Read mux; unmapped and write-only registers read zero
  function automatic logic [31:0] read_word(
    input swc_pkg::swc_state_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (reg_hit(s.hit, s.addr, swc_pkg::SWC_OFF_CONFIG)) begin
      w[swc_pkg::SWC_CFG_W-1:0] = s.cfg;
    end else if (reg_hit(s.hit, s.addr, swc_pkg::SWC_OFF_CTRL)) begin
      w[swc_pkg::SWC_CTRL_TYPE_LSB +: swc_pkg::SWC_TYPE_W] = s.slp_type;
    end else if (reg_hit(s.hit, s.addr, swc_pkg::SWC_OFF_WAKE_EN)) begin
      w[swc_pkg::SWC_WAKE_W-1:0] = s.wake_en;
    end else if (reg_hit(s.hit, s.addr, swc_pkg::SWC_OFF_STATUS)) begin
      w[swc_pkg::SWC_ST_W-1:0] = s.status;
    end else if (reg_hit(s.hit, s.addr, swc_pkg::SWC_OFF_IRQ_EN)) begin
      w[swc_pkg::SWC_ST_W-1:0] = s.irq_en;
    end else begin
      w = 32'h0000_0000;
    end
    read_word = w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // State

  swc_pkg::swc_state_t state_r;
  swc_pkg::swc_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic pwr_fall;
  logic [swc_pkg::SWC_WAKE_W-1:0] wake_rise;

  // Power-on request is active low; its falling edge is the request
  swc_sync_edge #(
    .W(1)
  ) u_pwr_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async(i_power_on_request_n),
    .o_level(),
    .o_rise(),
    .o_fall(pwr_fall)
  );

  // Wake sources count on their rising edge only
  swc_sync_edge #(
    .W(swc_pkg::SWC_WAKE_W)
  ) u_wake_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async(i_wake_event),
    .o_level(),
    .o_rise(wake_rise),
    .o_fall()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic addr_phase;
  logic data_write;
  logic wr_config;
  logic wr_ctrl;
  logic wr_wake_en;
  logic wr_clear;
  logic wr_irq_en;

  // Address phase taken when selected, NONSEQ/SEQ and bus ready
  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign data_write = (state_r.phase == swc_pkg::SWC_PH_WRITE);

  // Write strobes in the data phase, using the held address
  assign wr_config = data_write &&
    reg_hit(state_r.hit, state_r.addr, swc_pkg::SWC_OFF_CONFIG);
  assign wr_ctrl = data_write &&
    reg_hit(state_r.hit, state_r.addr, swc_pkg::SWC_OFF_CTRL);
  assign wr_wake_en = data_write &&
    reg_hit(state_r.hit, state_r.addr, swc_pkg::SWC_OFF_WAKE_EN);
  assign wr_clear = data_write &&
    reg_hit(state_r.hit, state_r.addr, swc_pkg::SWC_OFF_CLEAR);
  assign wr_irq_en = data_write &&
    reg_hit(state_r.hit, state_r.addr, swc_pkg::SWC_OFF_IRQ_EN);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep-enable write and its two outcomes

  logic slp_en_write;
  logic divert;
  logic sleep_start;
  logic [swc_pkg::SWC_TYPE_W-1:0] new_type;

  // A one in the enable bit of a control write is the request
  assign slp_en_write = wr_ctrl && i_hwdata[swc_pkg::SWC_CTRL_SLP_EN];
  assign divert = state_r.cfg[swc_pkg::SWC_CFG_DIVERT];
  assign new_type =
    i_hwdata[swc_pkg::SWC_CTRL_TYPE_LSB +: swc_pkg::SWC_TYPE_W];

  // Sequence starts only when not diverted to SMI
  assign sleep_start = slp_en_write && !divert;

  ////////////////////////////////////////////////////////////////////////////
  // Wake status sources

  logic wake_any;
  logic wake_set;

  // Enabled wake edges, masked per source
  assign wake_any = |(wake_rise & state_r.wake_en);

  // Power-on edge always counts; other wakes only with source bit set
  assign wake_set = pwr_fall ||
    (state_r.cfg[swc_pkg::SWC_CFG_WSRC] && wake_any);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status update

  logic [swc_pkg::SWC_ST_W-1:0] st_set;
  logic [swc_pkg::SWC_ST_W-1:0] st_clr;

  // Event bits in status layout
  always_comb begin
    st_set = '0;
    st_set[swc_pkg::SWC_ST_WAKE] = wake_set;
    st_set[swc_pkg::SWC_ST_SMI] = slp_en_write;
    st_set[swc_pkg::SWC_ST_SLEEP] = sleep_start;
  end

  // Write-one-to-clear; set is ORed after so a coincident event wins
  assign st_clr = wr_clear ? i_hwdata[swc_pkg::SWC_ST_W-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_nxt = state_r;
    state_nxt.req.start = 1'b0;

    // Bus phase tracker; reads take one wait so data come from a flop
    case (state_r.phase)
      swc_pkg::SWC_PH_RWAIT: begin
        state_nxt.rdata = read_word(state_r);
        state_nxt.phase = swc_pkg::SWC_PH_RDONE;
      end
      default: begin
        if (addr_phase) begin
          state_nxt.addr = i_haddr[7:0];
          state_nxt.hit = (i_haddr[31:8] == 24'h000000);
          state_nxt.phase = i_hwrite ? swc_pkg::SWC_PH_WRITE
                                     : swc_pkg::SWC_PH_RWAIT;
        end else begin
          state_nxt.phase = swc_pkg::SWC_PH_IDLE;
        end
      end
    endcase

    // Only the two defined bits are stored; the rest ignore writes
    if (wr_config) begin
      state_nxt.cfg = i_hwdata[swc_pkg::SWC_CFG_W-1:0];
    end

    // Sleep type is remembered on every control write
    if (wr_ctrl) begin
      state_nxt.slp_type = new_type;
    end

    if (wr_wake_en) begin
      state_nxt.wake_en = i_hwdata[swc_pkg::SWC_WAKE_W-1:0];
    end

    if (wr_irq_en) begin
      state_nxt.irq_en = i_hwdata[swc_pkg::SWC_ST_W-1:0];
    end

    // Sequencer gets a one-cycle start with the type of this write
    if (sleep_start) begin
      state_nxt.req.start = 1'b1;
      state_nxt.req.kind = new_type;
    end

    state_nxt.status = (state_r.status & ~st_clr) | st_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; battery power-on reset clears everything

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r.phase <= swc_pkg::SWC_PH_IDLE;
      state_r.addr <= swc_pkg::SWC_ADDR_RST;
      state_r.hit <= 1'b0;
      state_r.cfg <= swc_pkg::SWC_CFG_RST;
      state_r.slp_type <= swc_pkg::SWC_TYPE_RST;
      state_r.wake_en <= swc_pkg::SWC_WAKE_EN_RST;
      state_r.status <= swc_pkg::SWC_ST_RST;
      state_r.irq_en <= swc_pkg::SWC_IRQ_EN_RST;
      state_r.rdata <= swc_pkg::SWC_DATA_RST;
      state_r.req.start <= 1'b0;
      state_r.req.kind <= swc_pkg::SWC_TYPE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Wait only in the first read data cycle; always OKAY
  assign o_hreadyout = (state_r.phase != swc_pkg::SWC_PH_RWAIT);
  assign o_hresp = 1'b0;
  assign o_hrdata = state_r.rdata;

  assign o_sleep_req = state_r.req;
  assign o_wake_sts = state_r.status[swc_pkg::SWC_ST_WAKE];

  // Divert bit doubles as the flag's SMI enable
  assign o_smi = state_r.status[swc_pkg::SWC_ST_SMI] && divert;

  // Level interrupt while any enabled sticky bit stands
  assign o_irq = |(state_r.status & state_r.irq_en);

endmodule : swc_top
`default_nettype wire

/* tb/swc_top_properties.sv */
// Port-level assertions for the sleep/wake configuration block
`timescale 1ns/1ps
`default_nettype none
module swc_top_properties (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_power_on_request_n,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire swc_pkg::swc_sleep_req_t o_sleep_req,
  input wire logic o_wake_sts,
  input wire logic o_smi,
  input wire logic o_irq
);
  logic take;
  logic ctrl_q;
  logic clr_q;
  logic cfg_rd_q;
  // Address phase accepted at this edge
  assign take = i_hsel && i_htrans[1] && i_hready;
  // Data-phase markers, one cycle behind their address phase
  always_ff @(posedge i_clock) begin
    ctrl_q <= take && i_hwrite && i_haddr == {24'h00, swc_pkg::SWC_OFF_CTRL};
    clr_q <= take && i_hwrite && i_haddr == {24'h00, swc_pkg::SWC_OFF_CLEAR};
    cfg_rd_q <= take && !i_hwrite &&
      i_haddr == {24'h00, swc_pkg::SWC_OFF_CONFIG};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  //////////////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property (
    $fell(i_reset) |-> o_sleep_req == 4'h0 && !o_smi && !o_wake_sts && !o_irq)
    else $error("outputs not quiet after reset");
  chk_start_cause: assert property (
    o_sleep_req.start |-> $past(ctrl_q) && !o_smi)
    else $error("sleep start without an undiverted sleep write");
  chk_wake_hold: assert property (
    o_wake_sts && !clr_q |=> o_wake_sts)
    else $error("wake status dropped without a clear");
  chk_wake_fall: assert property (
    $fell(i_power_on_request_n) |-> ##[1:6] o_wake_sts)
    else $error("power-on fall did not set wake status");
  chk_cfg_reserved: assert property (
    cfg_rd_q |=> o_hreadyout && o_hrdata[31:2] == 30'h0)
    else $error("config reserved bits not zero");
  chk_read_wait: assert property (
    take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (
    take && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (
    o_hresp == 1'b0)
    else $error("response not okay");
  // Main scenarios reached
  cover property (o_sleep_req.start);
  cover property (o_smi);
  cover property ($rose(o_wake_sts));
  cover property (o_irq);
endmodule : swc_top_properties
bind swc_top swc_top_properties u_props (.i_clock, .i_reset, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_power_on_request_n,
  .o_hreadyout, .o_hresp, .o_hrdata, .o_sleep_req, .o_wake_sts, .o_smi,
  .o_irq);
`default_nettype wire

/* tb/swc_top_tb.sv */
// Self-checking bench for the sleep/wake configuration block
`timescale 1ns/1ps
`default_nettype none
module swc_top_tb;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ctrl;
    logic go;
    logic [31:0] st;
    logic smi;
  } swc_row_t;
  // Config, control write, start expected, status, smi
  swc_row_t rows [4] = '{
    '{32'h0, 32'hB, 1'b1, 32'h6, 1'b0},
    '{32'h1, 32'h7, 1'b0, 32'h2, 1'b1},
    '{32'h0, 32'hE, 1'b0, 32'h0, 1'b0},
    '{32'h1, 32'hC, 1'b0, 32'h0, 1'b0}};
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pon_n = 1'b1;
  logic [7:0] wev = 8'h00;
  logic hrdy;
  logic [31:0] hrdata;
  swc_pkg::swc_sleep_req_t sreq;
  logic wake;
  logic smi;
  logic irq;
  logic [31:0] q;
  int fails = 0;
  int samples_checked = 0;

  swc_top u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata),
    .i_power_on_request_n(pon_n), .i_wake_event(wev), .o_sleep_req(sreq),
    .o_wake_sts(wake), .o_smi(smi), .o_irq(irq));

  // 100 MHz clock
  always #5 i_clock = ~i_clock;

  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  // One single transfer; returns at the edge that ends its data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00, a};
    // Ready is read before the edge's updates, so it is the sampled value
    do @(posedge i_clock); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rdc

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    results();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    rdc(swc_pkg::SWC_OFF_CONFIG, 32'h0);
    foreach (rows[i]) begin
      wr(swc_pkg::SWC_OFF_CLEAR, 32'h7);
      wr(swc_pkg::SWC_OFF_CONFIG, rows[i].cfg);
      wr(swc_pkg::SWC_OFF_CTRL, rows[i].ctrl);
      @(negedge i_clock);
      cmp({31'h0, sreq.start}, {31'h0, rows[i].go});
      if (rows[i].go) cmp({29'h0, sreq.kind}, rows[i].ctrl[3:1]);
      rdc(swc_pkg::SWC_OFF_STATUS, rows[i].st);
      cmp({31'h0, smi}, {31'h0, rows[i].smi});
    end
    // Sleep type of the last control write reads back, enable bit reads 0
    rdc(swc_pkg::SWC_OFF_CTRL, 32'hC);
    // Reserved bits and unmapped space
    wr(swc_pkg::SWC_OFF_CONFIG, 32'hFFFF_FFFF);
    rdc(swc_pkg::SWC_OFF_CONFIG, 32'h3);
    rdc(8'h40, 32'h0);
    // Wake pin ignored while the source bit is clear
    wr(swc_pkg::SWC_OFF_CONFIG, 32'h0);
    wr(swc_pkg::SWC_OFF_CLEAR, 32'h7);
    wr(swc_pkg::SWC_OFF_WAKE_EN, 32'hFF);
    wev <= 8'h01;
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    pon_n <= 1'b0;
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h1);
    cmp({31'h0, wake}, 32'h1);
    // Source bit set: only enabled wake pins count
    pon_n <= 1'b1;
    wev <= 8'h00;
    wr(swc_pkg::SWC_OFF_CONFIG, 32'h2);
    wr(swc_pkg::SWC_OFF_WAKE_EN, 32'h0E);
    rdc(swc_pkg::SWC_OFF_WAKE_EN, 32'h0E);
    wr(swc_pkg::SWC_OFF_CLEAR, 32'h7);
    wev <= 8'h01;
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    wev <= 8'h09;
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h0);
    rdc(swc_pkg::SWC_OFF_STATUS, 32'h1);
    // Interrupt raised, masked, cleared
    wr(swc_pkg::SWC_OFF_IRQ_EN, 32'h1);
    @(negedge i_clock);
    cmp({31'h0, irq}, 32'h1);
    wr(swc_pkg::SWC_OFF_IRQ_EN, 32'h6);
    @(negedge i_clock);
    cmp({31'h0, irq}, 32'h0);
    rdc(swc_pkg::SWC_OFF_IRQ_EN, 32'h6);
    wr(swc_pkg::SWC_OFF_IRQ_EN, 32'h1);
    wr(swc_pkg::SWC_OFF_CLEAR, 32'h1);
    @(negedge i_clock);
    cmp({31'h0, irq}, 32'h0);
    // Second reset in mid-run clears the config
    wr(swc_pkg::SWC_OFF_CONFIG, 32'h3);
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rdc(swc_pkg::SWC_OFF_CONFIG, 32'h0);
    results();
  end
endmodule : swc_top_tb
`default_nettype wire
